// ==== hdl/scr_pkg.sv ====
/*
  Constants and carrier types for the sensor configuration register group.
  Assumes one device clock and a same-clock serial interface core in front.
*/
// Contract
// - Embedded page bit maps embedded registers; resets 0
// - Hub page bit exposes hub registers; resets 0
// - Aux pull-up disable resets 0; 1 disconnects both
// - Data-out pull-up enable resets 0; 1 connects
// - High select 0: frame equals twice low field
// - High select 1: frame twice (low plus 256*high)
// - Synchronization off when select 0, low zero
// - Ratio codes select delta-time resolution 2^11..2^14
// - Nine-bit watermark from low byte plus bit
// - Watermark flag when written count reaches threshold
// - Stop-at-watermark caps FIFO depth at threshold
// - Runtime compression effective only with feature enable
// - Rate-change marker bit batches marker records
// - Forced-uncompressed rate: none, every 8/16/32 events
package scr_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [6:0] ADDR_PAGE  = 7'h01;
  localparam logic [6:0] ADDR_PIN   = 7'h02;
  localparam logic [6:0] ADDR_FLOW  = 7'h04;
  localparam logic [6:0] ADDR_FHIGH = 7'h05;
  localparam logic [6:0] ADDR_RATIO = 7'h06;
  localparam logic [6:0] ADDR_WMLOW = 7'h07;
  localparam logic [6:0] ADDR_FCTL2 = 7'h08;

  // ==========================================================
  // Field positions
  localparam int BIT_EMB_PAGE   = 7;
  localparam int BIT_HUB_PAGE   = 6;
  localparam int BIT_AUX_PU_DIS = 7;
  localparam int BIT_DO_PU_EN   = 6;
  localparam int BIT_HIGH_SEL   = 7;
  localparam int BIT_STOP_WM    = 7;
  localparam int BIT_RT_COMPR   = 6;
  localparam int BIT_RATE_MARK  = 4;
  localparam int BIT_UNC_LO     = 1;
  localparam int BIT_WM_HIGH    = 0;

  // ==========================================================
  // Reset values and fixed bits
  localparam logic [7:0] RST_PAGE    = 8'h00;
  localparam logic [7:0] RST_PIN     = 8'h3f;
  localparam logic [7:0] PIN_FIXED   = 8'h3f;
  localparam logic [7:0] RST_ZERO    = 8'h00;
  localparam logic [7:0] MASK_PAGE   = 8'hc0;
  localparam logic [7:0] MASK_PIN    = 8'hc0;
  localparam logic [7:0] MASK_RATIO  = 8'h03;
  localparam logic [7:0] MASK_FCTL2  = 8'hd7;
  localparam logic [7:0] READ_UNMAP  = 8'h00;

  // ==========================================================
  // Timing and decode constants
  localparam int          FRAME_HIGH_WEIGHT = 256;
  localparam int          RES_LOG2_BASE     = 11;
  localparam logic [5:0]  UNC_PERIOD_1      = 6'h08;
  localparam logic [5:0]  UNC_PERIOD_2      = 6'h10;
  localparam logic [5:0]  UNC_PERIOD_3      = 6'h20;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    SCR_PAGE_MAIN = 2'b00,
    SCR_PAGE_EMB  = 2'b01,
    SCR_PAGE_HUB  = 2'b10
  } scr_page_e;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } scr_req_s;

  typedef struct packed {
    logic [8:0] threshold;
    logic       stopAtWatermark;
    logic       compressionActive;
    logic       rateChangeMarkerEnable;
    logic [1:0] forcedUncompressedRate;
  } scr_fifo_cfg_s;

endpackage

// ==== hdl/scr_config_regs.sv ====
/*
  Byte-wide configuration register group: page selection, pad pull-ups,
  sensor synchronization frame and resolution, FIFO watermark controls.
  Assumes the serial interface core and FIFO core run on mclk.
*/
`timescale 1ns/1ps
module scr_config_regs
(
  input  wire  logic                  mclk,
  input  wire  logic                  reset_n,
  input  wire  scr_pkg::scr_req_s     regReq,
  output logic [7:0]                  regRdata,
  output logic                        regRvalid,
  output scr_pkg::scr_page_e          pageSel,
  output logic                        embeddedPageSelect,
  output logic                        hubPageSelect,
  output logic                        auxPullupEnable,
  output logic                        dataoutPullupEnable,
  output logic                        syncEnable,
  output logic [16:0]                 syncFrameSamples,
  output logic [14:0]                 syncDeltaTimeResolution,
  input  wire  logic [8:0]            fifoWrittenCount,
  input  wire  logic                  compressionFeatureEnable,
  input  wire  logic                  batchEvent,
  output scr_pkg::scr_fifo_cfg_s      fifoCfg,
  output logic                        watermarkFlag,
  output logic                        fifoWriteStop,
  output logic                        forceUncompressed
);
  import scr_pkg::*;

  // ==========================================================
  // Reset release
  logic rstMeta_q;
  logic rstN_q;

  // Async assert, release through two flops
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rstMeta_q <= 1'b0;
      rstN_q    <= 1'b0;
    end
    else
    begin
      rstMeta_q <= 1'b1;
      rstN_q    <= rstMeta_q;
    end
  end

  // ==========================================================
  // Register storage
  logic [7:0] page_q;
  logic [7:0] pin_q;
  logic [7:0] frameLow_q;
  logic [7:0] frameHigh_q;
  logic [7:0] ratio_q;
  logic [7:0] wmLow_q;
  logic [7:0] fctl2_q;
  logic       onMain;
  logic       wrPage;
  logic       wrMain;

  // Only the page register answers while another page is mapped
  assign onMain = (pageSel == SCR_PAGE_MAIN);
  assign wrPage = regReq.wr && (regReq.addr == ADDR_PAGE);
  assign wrMain = regReq.wr && onMain;

  // Page register; six low bits held at zero since the host must zero them
  always_ff @(posedge mclk or negedge rstN_q)
  begin
    if (!rstN_q)
      page_q <= RST_PAGE;
    else if (wrPage)
      page_q <= regReq.wdata & MASK_PAGE;
  end

  // Pad pull-up control, fixed ones kept whatever is written
  always_ff @(posedge mclk or negedge rstN_q)
  begin
    if (!rstN_q)
      pin_q <= RST_PIN;
    else if (wrMain && regReq.addr == ADDR_PIN)
      pin_q <= (regReq.wdata & MASK_PIN) | PIN_FIXED;
  end

  // Synchronization frame and ratio registers
  always_ff @(posedge mclk or negedge rstN_q)
  begin
    if (!rstN_q)
    begin
      frameLow_q  <= RST_ZERO;
      frameHigh_q <= RST_ZERO;
      ratio_q     <= RST_ZERO;
    end
    else if (wrMain)
    begin
      if (regReq.addr == ADDR_FLOW)
        frameLow_q <= regReq.wdata;
      if (regReq.addr == ADDR_FHIGH)
        frameHigh_q <= regReq.wdata;
      if (regReq.addr == ADDR_RATIO)
        ratio_q <= regReq.wdata & MASK_RATIO;
    end
  end

  // FIFO watermark and control registers
  always_ff @(posedge mclk or negedge rstN_q)
  begin
    if (!rstN_q)
    begin
      wmLow_q <= RST_ZERO;
      fctl2_q <= RST_ZERO;
    end
    else if (wrMain)
    begin
      if (regReq.addr == ADDR_WMLOW)
        wmLow_q <= regReq.wdata;
      if (regReq.addr == ADDR_FCTL2)
        fctl2_q <= regReq.wdata & MASK_FCTL2;
    end
  end

  // ==========================================================
  // Read path
  logic [7:0] rdMux;

  // Unmapped offsets and other-page offsets read as zero
  always_comb
  begin
    rdMux = READ_UNMAP;
    if (regReq.addr == ADDR_PAGE)
      rdMux = page_q;
    else if (onMain)
    begin
      case (regReq.addr)
        ADDR_PIN:   rdMux = pin_q;
        ADDR_FLOW:  rdMux = frameLow_q;
        ADDR_FHIGH: rdMux = frameHigh_q;
        ADDR_RATIO: rdMux = ratio_q;
        ADDR_WMLOW: rdMux = wmLow_q;
        ADDR_FCTL2: rdMux = fctl2_q;
        default:    rdMux = READ_UNMAP;
      endcase
    end
  end

  // Read data lands one cycle after the request and holds
  always_ff @(posedge mclk or negedge rstN_q)
  begin
    if (!rstN_q)
    begin
      regRdata  <= READ_UNMAP;
      regRvalid <= 1'b0;
    end
    else
    begin
      regRvalid <= regReq.rd;
      if (regReq.rd)
        regRdata <= rdMux;
    end
  end

  // ==========================================================
  // Page and pad decode
  logic embBit;
  logic hubBit;

  assign embBit = page_q[BIT_EMB_PAGE];
  assign hubBit = page_q[BIT_HUB_PAGE];

  // Embedded page wins if both bits are set, keeping one page mapped
  always_comb
  begin
    case ({embBit, hubBit})
      2'b00:   pageSel = SCR_PAGE_MAIN;
      2'b01:   pageSel = SCR_PAGE_HUB;
      2'b10:   pageSel = SCR_PAGE_EMB;
      2'b11:   pageSel = SCR_PAGE_EMB;
      default: pageSel = SCR_PAGE_MAIN;
    endcase
  end

  // Page and pad levels straight from register flops
  assign embeddedPageSelect  = embBit;
  assign hubPageSelect       = hubBit;
  assign auxPullupEnable     = !pin_q[BIT_AUX_PU_DIS];
  assign dataoutPullupEnable = pin_q[BIT_DO_PU_EN];

  // ==========================================================
  // Synchronization decode
  logic        highSel;
  logic [6:0]  lowField;
  logic [16:0] frameCalc;

  assign highSel  = frameLow_q[BIT_HIGH_SEL];
  assign lowField = frameLow_q[6:0];

  // High byte only counts when selected
  always_comb
  begin
    if (highSel)
      frameCalc = {{9'h000, lowField} + 16'(FRAME_HIGH_WEIGHT) * {8'h00, frameHigh_q}, 1'b0};
    else
      frameCalc = {9'h000, lowField, 1'b0};
  end

  // Registered so the sync engine sees a settled value
  always_ff @(posedge mclk or negedge rstN_q)
  begin
    if (!rstN_q)
    begin
      syncFrameSamples        <= 17'h00000;
      syncEnable              <= 1'b0;
      syncDeltaTimeResolution <= 15'h0000;
    end
    else
    begin
      syncFrameSamples        <= frameCalc;
      syncEnable              <= highSel || (lowField != 7'h00);
      syncDeltaTimeResolution <= 15'(15'h0001 << (RES_LOG2_BASE + int'(ratio_q[1:0])));
    end
  end

  // ==========================================================
  // FIFO controls
  logic [8:0] threshold;
  logic       stopBit;

  assign threshold = {fctl2_q[BIT_WM_HIGH], wmLow_q};
  assign stopBit   = fctl2_q[BIT_STOP_WM];

  // Config word and watermark status, one cycle behind their causes
  always_ff @(posedge mclk or negedge rstN_q)
  begin
    if (!rstN_q)
    begin
      fifoCfg       <= '0;
      watermarkFlag <= 1'b0;
      fifoWriteStop <= 1'b0;
    end
    else
    begin
      fifoCfg.threshold              <= threshold;
      fifoCfg.stopAtWatermark        <= stopBit;
      fifoCfg.compressionActive      <= fctl2_q[BIT_RT_COMPR] && compressionFeatureEnable;
      fifoCfg.rateChangeMarkerEnable <= fctl2_q[BIT_RATE_MARK];
      fifoCfg.forcedUncompressedRate <= fctl2_q[BIT_UNC_LO +: 2];
      watermarkFlag                  <= fifoWrittenCount >= threshold;
      fifoWriteStop                  <= stopBit && (fifoWrittenCount >= threshold);
    end
  end

  // ==========================================================
  // Forced-uncompressed insertion
  logic [5:0] uncPeriod;
  logic [5:0] batchCount_q;

  // Period per rate code; zero means never force
  always_comb
  begin
    case (fctl2_q[BIT_UNC_LO +: 2])
      2'b01:   uncPeriod = UNC_PERIOD_1;
      2'b10:   uncPeriod = UNC_PERIOD_2;
      2'b11:   uncPeriod = UNC_PERIOD_3;
      default: uncPeriod = 6'h00;
    endcase
  end

  // Counts batch events; reaching the period or rate code 0 clears the count, a change between nonzero codes keeps it
  always_ff @(posedge mclk or negedge rstN_q)
  begin
    if (!rstN_q)
    begin
      batchCount_q      <= 6'h00;
      forceUncompressed <= 1'b0;
    end
    else
    begin
      forceUncompressed <= 1'b0;
      if (uncPeriod == 6'h00)
        batchCount_q <= 6'h00;
      else if (batchEvent)
      begin
        if (batchCount_q >= uncPeriod - 6'h01)
        begin
          batchCount_q      <= 6'h00;
          forceUncompressed <= 1'b1;
        end
        else
          batchCount_q <= batchCount_q + 6'h01;
      end
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstN_q);

  sequence s_write(logic [6:0] a);
    regReq.wr && regReq.addr == a && onMain;
  endsequence

  sequence s_read(logic [6:0] a);
    regReq.rd && regReq.addr == a && onMain;
  endsequence

  a_page_zero_bits: assert property (wrPage |=> page_q[5:0] == 6'h00 &&
    page_q[7:6] == $past(regReq.wdata[7:6]))
    else $error("page register low bits not zero");
  a_pin_fixed_ones: assert property (s_read(ADDR_PIN) |=> regRvalid &&
    regRdata[5:0] == 6'h3f)
    else $error("pull-up register fixed bits wrong");
  a_aux_pullup_pads: assert property (s_write(ADDR_PIN) |=>
    auxPullupEnable == !$past(regReq.wdata[7]))
    else $error("aux pull-up not following write");
  a_frame_low_mode: assert property (!highSel |=>
    syncFrameSamples == 17'($past(lowField)) * 17'h00002)
    else $error("low-mode frame wrong");
  a_frame_high_mode: assert property (highSel |=> syncFrameSamples ==
    17'h00002 * (17'($past(lowField)) + 17'h00100 * 17'($past(frameHigh_q))))
    else $error("high-mode frame wrong");
  a_sync_disabled: assert property (!highSel && lowField == 7'h00 |=> !syncEnable)
    else $error("sync not disabled");
  a_ratio_decode: assert property (ratio_q[1:0] == 2'b11 |=>
    syncDeltaTimeResolution == 15'h4000)
    else $error("resolution decode wrong");
  // Sampled reset in the antecedent: the flag flop is still held on the release edge
  a_watermark_flag: assert property (rstN_q && fifoWrittenCount >= threshold |=>
    watermarkFlag ##0 fifoCfg.threshold == $past(threshold))
    else $error("watermark flag missing");
  a_stop_cap: assert property (fifoWriteStop |-> $past(stopBit) &&
    $past(fifoWrittenCount) >= $past(threshold))
    else $error("depth capped without cause");
  a_compr_gate: assert property (!compressionFeatureEnable |=> !fifoCfg.compressionActive)
    else $error("compression active without feature");
  a_unc_never: assert property (uncPeriod == 6'h00 |=> !forceUncompressed)
    else $error("uncompressed forced at rate zero");

endmodule

// ==== test/scr_host_model.sv ====
/*
  Host model on the register port: one-cycle write and read pulses.
  Assumes the register group takes requests on the rising edge of mclk.
*/
`timescale 1ns/1ps
module scr_host_model
(
  input  wire  logic        mclk,
  output scr_pkg::scr_req_s regReq,
  input  wire  logic [7:0]  regRdata,
  input  wire  logic        regRvalid
);
  import scr_pkg::*;

  // ==========================================================
  // Bus cycles
  initial regReq = '0;

  // Write pulse, released on the edge that takes it
  task automatic wrReg(input logic [6:0] a, input logic [7:0] d);
    @(posedge mclk);
    regReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge mclk);
    regReq <= '0;
  endtask

  // Low six page bits are always sent as zero to keep the device sane
  task automatic setPage(input logic emb, input logic hub);
    wrReg(ADDR_PAGE, {emb, hub, 6'h00});
  endtask

  // Read pulse; data and valid are registered on the taking edge and sampled 1 ns after it
  task automatic rdReg(input logic [6:0] a, output logic [7:0] d, output logic v);
    @(posedge mclk);
    regReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge mclk);
    regReq <= '0;
    #1;
    d = regRdata;
    v = regRvalid;
  endtask
endmodule

// ==== test/tb_top.sv ====
/*
  Self-checking bench for the configuration register group.
  Assumes a single 100 MHz clock and the host model in front of the port.
*/
`timescale 1ns/1ps
module tb_top;
  import scr_pkg::*;

  // ==========================================================
  // Signals
  logic          mclk;
  logic          reset_n;
  scr_req_s      regReq;
  logic [7:0]    regRdata;
  logic          regRvalid;
  scr_page_e     pageSel;
  logic          embSel;
  logic          hubSel;
  logic          auxPu;
  logic          doPu;
  logic          syncEnable;
  logic [16:0]   frame;
  logic [14:0]   dtRes;
  logic [8:0]    fifoWrittenCount;
  logic          comprEn;
  logic          batchEvent;
  scr_fifo_cfg_s fifoCfg;
  logic          wmFlag;
  logic          wrStop;
  logic          forceUnc;
  int            errors;
  int            num_checks;
  int            cycles;
  int            uncPulses;
  logic [6:0]    tAddr [6] = '{ADDR_PIN, ADDR_RATIO, ADDR_FCTL2, ADDR_FLOW, ADDR_FHIGH, ADDR_WMLOW};
  logic [7:0]    tExp  [6] = '{8'hff, 8'h03, 8'hd7, 8'hff, 8'hff, 8'hff};

  // ==========================================================
  // Clock, design and host
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  scr_config_regs uut (.mclk(mclk), .reset_n(reset_n), .regReq(regReq),
    .regRdata(regRdata), .regRvalid(regRvalid), .pageSel(pageSel),
    .embeddedPageSelect(embSel), .hubPageSelect(hubSel), .auxPullupEnable(auxPu),
    .dataoutPullupEnable(doPu), .syncEnable(syncEnable), .syncFrameSamples(frame),
    .syncDeltaTimeResolution(dtRes), .fifoWrittenCount(fifoWrittenCount),
    .compressionFeatureEnable(comprEn), .batchEvent(batchEvent), .fifoCfg(fifoCfg),
    .watermarkFlag(wmFlag), .fifoWriteStop(wrStop), .forceUncompressed(forceUnc));

  scr_host_model host (.mclk(mclk), .regReq(regReq), .regRdata(regRdata),
    .regRvalid(regRvalid));

  // ==========================================================
  // Helpers
  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic rdChk(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic       v;
    host.rdReg(a, d, v);
    check(17'(d), 17'(e));
    check(17'(v), 17'h1);
  endtask

  // Derived outputs lag the register by one further cycle
  task automatic settle();
    repeat (2) @(posedge mclk);
    #1;
  endtask

  task automatic evt();
    @(posedge mclk);
    batchEvent <= 1'b1;
    @(posedge mclk);
    batchEvent <= 1'b0;
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Pulse counter; timeout guards against a hung handshake
  always @(posedge mclk)
  begin
    cycles++;
    if (forceUnc === 1'b1)
      uncPulses++;
    if (cycles == 5000)
    begin
      errors++;
      conclude();
    end
  end

  // ==========================================================
  // Tests
  initial
  begin
    errors = 0;
    num_checks = 0;
    cycles = 0;
    uncPulses = 0;
    reset_n = 1'b0;
    fifoWrittenCount = 9'h000;
    comprEn = 1'b0;
    batchEvent = 1'b0;
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    check(17'(auxPu), 17'h1);
    check(17'(doPu), 17'h0);
    check(17'(pageSel), 17'(SCR_PAGE_MAIN));
    check(17'(syncEnable), 17'h0);
    rdChk(ADDR_PAGE, 8'h00);
    rdChk(ADDR_PIN, 8'h3f);
    rdChk(ADDR_FCTL2, 8'h00);
    check(17'(fifoCfg.stopAtWatermark), 17'h0);
    $display("reset test done");
    // Fixed bits hold their constant against an all-ones write
    for (int i = 0; i < 6; i++)
    begin
      host.wrReg(tAddr[i], 8'hff);
      rdChk(tAddr[i], tExp[i]);
    end
    check(17'(auxPu), 17'h0);
    check(17'(doPu), 17'h1);
    host.wrReg(ADDR_PIN, 8'h00);
    rdChk(ADDR_PIN, 8'h3f);
    check(17'(auxPu), 17'h1);
    check(17'(doPu), 17'h0);
    $display("fixed bit test done");
    // Frame formula, largest frame, disable case and ratio codes
    settle();
    check(frame, 17'd130814);
    host.wrReg(ADDR_FHIGH, 8'h03);
    host.wrReg(ADDR_FLOW, 8'h05);
    settle();
    check(frame, 17'd10);
    check(17'(syncEnable), 17'h1);
    host.wrReg(ADDR_FLOW, 8'h85);
    settle();
    check(frame, 17'd1546);
    host.wrReg(ADDR_FLOW, 8'h00);
    settle();
    check(17'(syncEnable), 17'h0);
    host.wrReg(ADDR_FLOW, 8'h80);
    settle();
    check(17'(syncEnable), 17'h1);
    check(frame, 17'd1536);
    for (int c = 0; c < 4; c++)
    begin
      host.wrReg(ADDR_RATIO, 8'(c));
      settle();
      check(17'(dtRes), 17'h1 << (11 + c));
    end
    $display("sync test done");
    // Watermark just below and at the nine-bit threshold
    host.wrReg(ADDR_WMLOW, 8'h10);
    host.wrReg(ADDR_FCTL2, 8'h81);
    @(posedge mclk);
    fifoWrittenCount <= 9'h10f;
    settle();
    check(17'(fifoCfg.threshold), 17'h110);
    check(17'(wmFlag), 17'h0);
    check(17'(wrStop), 17'h0);
    check(17'(fifoCfg.stopAtWatermark), 17'h1);
    @(posedge mclk);
    fifoWrittenCount <= 9'h110;
    settle();
    check(17'(wmFlag), 17'h1);
    check(17'(wrStop), 17'h1);
    host.wrReg(ADDR_FCTL2, 8'h01);
    settle();
    check(17'(wrStop), 17'h0);
    check(17'(fifoCfg.stopAtWatermark), 17'h0);
    check(17'(wmFlag), 17'h1);
    $display("watermark test done");
    // Runtime compression gated by the feature enable; marker bit
    host.wrReg(ADDR_FCTL2, 8'h50);
    settle();
    check(17'(fifoCfg.compressionActive), 17'h0);
    check(17'(fifoCfg.rateChangeMarkerEnable), 17'h1);
    @(posedge mclk);
    comprEn <= 1'b1;
    settle();
    check(17'(fifoCfg.compressionActive), 17'h1);
    $display("compression test done");
    // Forced uncompressed: every 8, 16 or 32 events, none for code 0
    for (int r = 0; r < 4; r++)
    begin
      host.wrReg(ADDR_FCTL2, 8'h00);
      host.wrReg(ADDR_FCTL2, 8'(r << 1));
      settle();
      check(17'(fifoCfg.forcedUncompressedRate), 17'(r));
      check(17'(fifoCfg.rateChangeMarkerEnable), 17'h0);
      uncPulses = 0;
      repeat ((r == 0) ? 40 : (4 << r) - 1) evt();
      repeat (2) @(posedge mclk);
      check(17'(uncPulses), 17'h0);
      evt();
      repeat (2) @(posedge mclk);
      check(17'(uncPulses), (r == 0) ? 17'h0 : 17'h1);
    end
    $display("uncompressed test done");
    // Page selection hides the main page; unmapped offset reads zero
    host.setPage(1'b1, 1'b0);
    #1;
    check(17'(embSel), 17'h1);
    check(17'(pageSel), 17'(SCR_PAGE_EMB));
    rdChk(ADDR_WMLOW, 8'h00);
    host.wrReg(ADDR_WMLOW, 8'h22);
    host.setPage(1'b0, 1'b1);
    #1;
    check(17'(hubSel), 17'h1);
    check(17'(pageSel), 17'(SCR_PAGE_HUB));
    rdChk(ADDR_PAGE, 8'h40);
    // Both page bits set: the embedded page takes precedence
    host.setPage(1'b1, 1'b1);
    #1;
    check(17'(pageSel), 17'(SCR_PAGE_EMB));
    host.setPage(1'b0, 1'b0);
    rdChk(ADDR_WMLOW, 8'h10);
    rdChk(7'h03, 8'h00);
    $display("page test done");
    conclude();
  end
endmodule
